// ==== rtl/sce_map.svh ====
`ifndef SCE_MAP_SVH
`define SCE_MAP_SVH

// ----------------------------------------------------------------------------
// bus map (byte addresses)
// ----------------------------------------------------------------------------
`define SCE_ADDR_CTRL    12'h000
`define SCE_ADDR_STAT    12'h004
`define SCE_ADDR_OUT     12'h008
`define SCE_NV_PAGE      4'h1
`define SCE_NV_BYTES     6'h30
`define SCE_CTRL_RESET   3'h0
`define SCE_CTRL_DIGITAL 0
`define SCE_CTRL_ALARM   1
`define SCE_CTRL_STEER   2

// ----------------------------------------------------------------------------
// configuration byte indices
// ----------------------------------------------------------------------------
`define SCE_B_COARSE     6'h02
`define SCE_B_SPAN       6'h03
`define SCE_B_ZERO       6'h04
`define SCE_B_COEF_LO    6'h05
`define SCE_B_COEF_HI    6'h0D
`define SCE_B_MSB        6'h11
`define SCE_B_TBP        6'h12
`define SCE_B_COUNT      6'h18
`define SCE_B_ALM_LT     6'h1B
`define SCE_B_ALM_LO     6'h1C
`define SCE_B_ALM_HT     6'h1D
`define SCE_B_ALM_HO     6'h1E
`define SCE_B_SRC        6'h1F
`define SCE_B_SBP        6'h20
`define SCE_B_ORD        6'h28

// ----------------------------------------------------------------------------
// fields, codes and scaling
// ----------------------------------------------------------------------------
`define SCE_F_SPAN_MSB   1:0
`define SCE_F_ZERO_MSB   5:4
`define SCE_F_CSPAN      2:0
`define SCE_F_CZERO      7:4
`define SCE_F_SRC        7:4
`define SCE_F_SIG_CNT    7:4
`define SCE_F_TMP_CNT    3:0
`define SCE_F_TEMP       15:6
`define SCE_F_BP_HI      1:0
`define SCE_COEF_DIR     11
`define SCE_COEF_MAG     10:0
`define SCE_COEF_SLOTS   8
`define SCE_TCNT_FIXED   4'h0
`define SCE_TCNT_TWO     4'h5
`define SCE_TCNT_THREE   4'h8
`define SCE_TCNT_FOUR    4'hB
`define SCE_SIG_MAX_T1   3'h5
`define SCE_SIG_MAX_T2   3'h3
`define SCE_SIG_MAX_T3   3'h2
`define SCE_SIG_MAX_T4   3'h1
`define SCE_TC_SHIFT     8
`define SCE_PC_SHIFT     10
`define SCE_DAC_MAX      10'h3FF
`define SCE_SRC_TEMP     4'h2
`define SCE_SRC_AMP      4'h6
`define SCE_SRC_SENSOR   4'h0
`define SCE_SRC_VOUT     4'h3
`define SCE_SRC_AUX1     4'h4
`define SCE_SRC_AUX2     4'h5

`endif

// ==== rtl/sce_pkg.sv ====
`include "sce_map.svh"

package sce_pkg;
   typedef logic [9:0]         dac_type;
   typedef logic signed [23:0] acc_type;
   typedef logic [1:0]         seg_type;
   typedef enum logic [3:0] {
      SRC_SENSOR = `SCE_SRC_SENSOR,
      SRC_TEMP   = `SCE_SRC_TEMP,
      SRC_VOUT   = `SCE_SRC_VOUT,
      SRC_AUX1   = `SCE_SRC_AUX1,
      SRC_AUX2   = `SCE_SRC_AUX2,
      SRC_AMP    = `SCE_SRC_AMP
   } src_type;
endpackage

// ==== rtl/sensor_compensation_engine.sv ====
// Implementation choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "sce_map.svh"
// Contract
// - after reset, recompute span and zero DAC settings continuously, up to four segments
// - segment one: fixed span minus coefficient times (first breakpoint minus temperature)
// - later segments add coefficient times distance above lower breakpoint, chained
// - coefficient flag bit: segment one rises, segments two to four fall
// - zero DAC uses the same piecewise procedure with zero coefficients
// - fixed span built from configuration bytes 3 and 17
// - fixed zero built from configuration bytes 4 and 17
// - coarse span and coarse zero selections both come from byte 2
// - digital mode: output = (signal - breakpoint) * coefficient + ordinate, five ranges
// - signal coefficient: sign bit, unity bit, ten fraction bits
// - signal breakpoints are 10-bit, high byte first then low byte
// - point-count byte: upper nibble signal points, lower nibble temperature points
// - temperature nibble 0 fixed, 5 two, 8 three, 11 four segments
// - shared storage allows only 1/5, 2/3, 3/2, 4/1 segment pairings
// - alarm: five bytes; force programmed level when output passes a limit; the code compares the signal selected by byte 31 instead
// - alarm thresholds compare with upper 8 bits of the 10-bit signal
// - source selected by upper nibble of byte 31 with fixed codes
// - level steering drives both aux pins with level of selected signal
// - level steering and alarm never active together
// - level steering: byte 31 selects input, three bytes give transition levels
// - alarm disabled whenever level steering is enabled
// - filtered temperature is 10 bits left-justified in a 16-bit field

module sensor_compensation_engine (
   // clock, reset, enable
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // measured signals, same clock domain
   input  wire logic [15:0] temperature_filtered,
   input  wire logic [9:0]  temperature_signal,
   input  wire logic [9:0]  amplifier_signal,
   input  wire logic [9:0]  sensor_signal,
   input  wire logic [9:0]  voltage_output,
   input  wire logic [9:0]  first_aux_level,
   input  wire logic [9:0]  second_aux_level,
   // dac settings and corrected output
   output logic      [9:0]  span_dac,
   output logic      [9:0]  zero_dac,
   output logic      [2:0]  coarse_span_select,
   output logic      [3:0]  coarse_zero_select,
   output logic      [9:0]  corrected_out,
   output logic             alarm_active,
   // aux pins
   output logic             first_aux_pin_out,
   output logic             first_aux_pin_oe,
   output logic             second_aux_pin_out,
   output logic             second_aux_pin_oe
);

   // -------------------------------------------------------------------------
   // storage
   // -------------------------------------------------------------------------
   logic [7:0]         nv_r [48];
   logic [2:0]         ctrl_r;
   logic               pready_r;
   logic               pslverr_r;
   logic [31:0]        prdata_r;
   sce_pkg::dac_type   span_r;
   sce_pkg::dac_type   zero_r;
   logic [2:0]         cspan_r;
   logic [3:0]         czero_r;
   sce_pkg::dac_type   out_r;
   logic               alarm_r;
   logic [1:0]         steer_r;
   logic               steer_oe_r;
   sce_pkg::seg_type   tseg_r;
   logic [2:0]         sseg_r;

   // -------------------------------------------------------------------------
   // arithmetic helpers
   // -------------------------------------------------------------------------
   function automatic sce_pkg::acc_type tc_term(input logic [11:0] c,
                                                input logic signed [11:0] dt,
                                                input logic neg);
      sce_pkg::acc_type a;
      sce_pkg::acc_type b;
      sce_pkg::acc_type p;
      a = {13'h0000, c[`SCE_COEF_MAG]};
      b = {{12{dt[11]}}, dt};
      p = (a * b) >>> `SCE_TC_SHIFT;
      return neg ? -p : p;
   endfunction

   function automatic logic signed [11:0] tdiff(input logic [9:0] a, input logic [9:0] b);
      return $signed({2'b00, a}) - $signed({2'b00, b});
   endfunction

   // saturate rather than wrap: a wrapped dac code would swing the bridge rail to rail
   function automatic sce_pkg::dac_type clamp10(input sce_pkg::acc_type v);
      if (v < 0)
         return 10'h000;
      if (v > $signed({14'h0000, `SCE_DAC_MAX}))
         return `SCE_DAC_MAX;
      return v[9:0];
   endfunction

   // piecewise temperature compensation, nseg holds segment count minus one
   function automatic sce_pkg::acc_type piece(input logic [9:0] fx,
                                              input logic [11:0] c1,
                                              input logic [11:0] c2,
                                              input logic [11:0] c3,
                                              input logic [11:0] c4,
                                              input logic [9:0] t,
                                              input logic [9:0] b1,
                                              input logic [9:0] b2,
                                              input logic [9:0] b3,
                                              input sce_pkg::seg_type nseg);
      sce_pkg::acc_type acc;
      acc = {14'h0000, fx};
      if (nseg == 2'h0)
         return acc;
      if (t < b1)
         return acc + tc_term(c1, tdiff(b1, t), !c1[`SCE_COEF_DIR]);
      if (nseg == 2'h1 || t < b2)
         return acc + tc_term(c2, tdiff(t, b1), c2[`SCE_COEF_DIR]);
      acc = acc + tc_term(c2, tdiff(b2, b1), c2[`SCE_COEF_DIR]);
      if (nseg == 2'h2 || t < b3)
         return acc + tc_term(c3, tdiff(t, b2), c3[`SCE_COEF_DIR]);
      acc = acc + tc_term(c3, tdiff(b3, b2), c3[`SCE_COEF_DIR]);
      return acc + tc_term(c4, tdiff(t, b3), c4[`SCE_COEF_DIR]);
   endfunction

   // -------------------------------------------------------------------------
   // configuration decode
   // -------------------------------------------------------------------------
   logic [11:0]        coef [`SCE_COEF_SLOTS];
   logic [9:0]         tbp [3];
   logic [9:0]         sbp [5];
   logic [9:0]         fixed_span;
   logic [9:0]         fixed_zero;
   logic [9:0]         temp_f;
   sce_pkg::seg_type   nseg;
   logic [2:0]         nsig;
   logic [2:0]         sig_max;
   logic [3:0]         tcode;
   logic [3:0]         scnt;

   // coefficient slots are shared: temperature pairs from the bottom, signal from the top
   always_comb begin
      for (int s = 0; s < `SCE_COEF_SLOTS; s++) begin
         coef[s] = {s[0] ? nv_r[`SCE_B_COEF_HI + s / 2][7:4] : nv_r[`SCE_B_COEF_HI + s / 2][3:0],
                    nv_r[`SCE_B_COEF_LO + s]};
      end
      for (int k = 0; k < 3; k++) begin
         tbp[k] = {nv_r[`SCE_B_TBP + 2 * k][`SCE_F_BP_HI], nv_r[`SCE_B_TBP + 2 * k + 1]};
      end
      sbp[0] = 10'h000;
      for (int k = 1; k < 5; k++) begin
         sbp[k] = {nv_r[`SCE_B_SBP + 2 * k - 2][`SCE_F_BP_HI], nv_r[`SCE_B_SBP + 2 * k - 1]};
      end
   end

   assign fixed_span = {nv_r[`SCE_B_MSB][`SCE_F_SPAN_MSB], nv_r[`SCE_B_SPAN]};
   assign fixed_zero = {nv_r[`SCE_B_MSB][`SCE_F_ZERO_MSB], nv_r[`SCE_B_ZERO]};
   assign temp_f     = temperature_filtered[`SCE_F_TEMP];
   assign tcode      = nv_r[`SCE_B_COUNT][`SCE_F_TMP_CNT];
   assign scnt       = nv_r[`SCE_B_COUNT][`SCE_F_SIG_CNT];

   // unknown temperature codes fall back to fixed compensation
   always_comb begin
      nseg    = 2'h0;
      sig_max = `SCE_SIG_MAX_T1;
      case (tcode)
         `SCE_TCNT_TWO: begin
            nseg    = 2'h1;
            sig_max = `SCE_SIG_MAX_T2;
         end
         `SCE_TCNT_THREE: begin
            nseg    = 2'h2;
            sig_max = `SCE_SIG_MAX_T3;
         end
         `SCE_TCNT_FOUR: begin
            nseg    = 2'h3;
            sig_max = `SCE_SIG_MAX_T4;
         end
         default: begin
            nseg    = 2'h0;
            sig_max = `SCE_SIG_MAX_T1;
         end
      endcase
   end

   // signal range count limited by what the temperature side leaves free
   always_comb begin
      if (scnt == 4'h0)
         nsig = 3'h1;
      else if (scnt > {1'b0, sig_max})
         nsig = sig_max;
      else
         nsig = scnt[2:0];
   end

   // -------------------------------------------------------------------------
   // compensation and signal correction
   // -------------------------------------------------------------------------
   sce_pkg::dac_type   span_nxt;
   sce_pkg::dac_type   zero_nxt;
   sce_pkg::seg_type   tseg_nxt;
   logic [2:0]         sseg_nxt;
   sce_pkg::dac_type   corr;
   sce_pkg::acc_type   sprod;
   logic [9:0]         sdiff;
   logic [11:0]        pc;
   int                 slot;

   // span uses even slots, zero the odd ones
   assign span_nxt = clamp10(piece(fixed_span, coef[0], coef[2], coef[4], coef[6], temp_f,
                                   tbp[0], tbp[1], tbp[2], nseg));
   assign zero_nxt = clamp10(piece(fixed_zero, coef[1], coef[3], coef[5], coef[7], temp_f,
                                   tbp[0], tbp[1], tbp[2], nseg));

   // active temperature segment, reported in the output register
   always_comb begin
      if (nseg == 2'h0 || temp_f < tbp[0])
         tseg_nxt = 2'h0;
      else if (nseg == 2'h1 || temp_f < tbp[1])
         tseg_nxt = 2'h1;
      else if (nseg == 2'h2 || temp_f < tbp[2])
         tseg_nxt = 2'h2;
      else
         tseg_nxt = 2'h3;
   end

   // highest configured range whose breakpoint the signal has reached
   always_comb begin
      sseg_nxt = 3'h0;
      for (int k = 1; k < 5; k++) begin
         if (k < int'(nsig) && sensor_signal >= sbp[k])
            sseg_nxt = 3'(k);
      end
      slot  = `SCE_COEF_SLOTS - int'(nsig) + int'(sseg_nxt);
      pc    = coef[slot[2:0]];
      sdiff = sensor_signal - sbp[sseg_nxt];
      sprod = ($signed({14'h0000, sdiff}) * $signed({13'h0000, pc[`SCE_COEF_MAG]}))
              >>> `SCE_PC_SHIFT;
      if (pc[`SCE_COEF_DIR])
         sprod = -sprod;
      corr  = clamp10(sprod + $signed({14'h0000, nv_r[`SCE_B_ORD + sseg_nxt], 2'b00}));
   end

   // -------------------------------------------------------------------------
   // alarm limiting and level steering
   // -------------------------------------------------------------------------
   sce_pkg::src_type   src_code;
   logic [9:0]         src_val;
   logic [7:0]         src_lvl;
   logic               alarm_on;
   logic               alarm_nxt;
   sce_pkg::dac_type   out_nxt;
   logic [1:0]         steer_nxt;

   assign src_code = sce_pkg::src_type'(nv_r[`SCE_B_SRC][`SCE_F_SRC]);
   assign src_lvl  = src_val[9:2];
   // steering owns the shared comparators, so it wins over the alarm enable
   assign alarm_on = ctrl_r[`SCE_CTRL_ALARM] & ~ctrl_r[`SCE_CTRL_STEER];

   // undefined source codes watch the sensor signal
   always_comb begin
      case (src_code)
         sce_pkg::SRC_TEMP: src_val = temperature_signal;
         sce_pkg::SRC_AMP:  src_val = amplifier_signal;
         sce_pkg::SRC_VOUT: src_val = voltage_output;
         sce_pkg::SRC_AUX1: src_val = first_aux_level;
         sce_pkg::SRC_AUX2: src_val = second_aux_level;
         default:           src_val = sensor_signal;
      endcase
   end

   // limits force the programmed level; below-low is checked first
   always_comb begin
      out_nxt   = ctrl_r[`SCE_CTRL_DIGITAL] ? corr : sensor_signal;
      alarm_nxt = 1'b0;
      if (alarm_on && src_lvl < nv_r[`SCE_B_ALM_LT]) begin
         out_nxt   = {nv_r[`SCE_B_ALM_LO], 2'b00};
         alarm_nxt = 1'b1;
      end else if (alarm_on && src_lvl > nv_r[`SCE_B_ALM_HT]) begin
         out_nxt   = {nv_r[`SCE_B_ALM_HO], 2'b00};
         alarm_nxt = 1'b1;
      end
   end

   // binary count of crossed transition levels, zero when steering is off
   always_comb begin
      steer_nxt = 2'h0;
      if (ctrl_r[`SCE_CTRL_STEER]) begin
         steer_nxt = 2'(src_lvl >= nv_r[`SCE_B_ALM_LT]) + 2'(src_lvl >= nv_r[`SCE_B_ALM_LO])
                   + 2'(src_lvl >= nv_r[`SCE_B_ALM_HT]);
      end
   end

   // -------------------------------------------------------------------------
   // apb slave: one wait state, writes land on the completing edge
   // -------------------------------------------------------------------------
   logic               acc_phase;
   logic               nv_hit;
   logic               hit;
   logic [5:0]         nv_idx;
   logic [31:0]        rd_nxt;

   assign acc_phase = psel & penable;
   assign nv_idx    = paddr[7:2];
   assign nv_hit    = paddr[11:8] == `SCE_NV_PAGE && nv_idx < `SCE_NV_BYTES
                      && paddr[1:0] == 2'b00;

   always_comb begin
      hit    = 1'b1;
      rd_nxt = 32'h0000_0000;
      if (nv_hit)
         rd_nxt = {24'h00_0000, nv_r[nv_idx]};
      else if (paddr == `SCE_ADDR_CTRL)
         rd_nxt = {29'h0000_0000, ctrl_r};
      else if (paddr == `SCE_ADDR_STAT)
         rd_nxt = {6'h00, zero_r, 6'h00, span_r};
      else if (paddr == `SCE_ADDR_OUT)
         rd_nxt = {16'h0000, alarm_r, tseg_r, sseg_r, out_r};
      else
         hit = 1'b0;
   end

   // pready rises one cycle into the access phase and drops after the completing edge
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else if (ce) begin
         pready_r  <= acc_phase & ~pready_r;
         pslverr_r <= acc_phase & ~pready_r & ~hit;
         if (acc_phase && !pready_r)
            prdata_r <= pwrite ? 32'h0000_0000 : rd_nxt;
      end
   end

   // configuration image and mode bits; edits take effect from the next cycle
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ctrl_r <= `SCE_CTRL_RESET;
         for (int i = 0; i < 48; i++) begin
            nv_r[i] <= 8'h00;
         end
      end else if (ce && acc_phase && pready_r && pwrite && pstrb[0]) begin
         if (nv_hit)
            nv_r[nv_idx] <= pwdata[7:0];
         else if (paddr == `SCE_ADDR_CTRL)
            ctrl_r <= pwdata[2:0];
      end
   end

   // -------------------------------------------------------------------------
   // output registers, refreshed every enabled cycle
   // -------------------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         span_r     <= 10'h000;
         zero_r     <= 10'h000;
         cspan_r    <= 3'h0;
         czero_r    <= 4'h0;
         out_r      <= 10'h000;
         alarm_r    <= 1'b0;
         steer_r    <= 2'h0;
         steer_oe_r <= 1'b0;
         tseg_r     <= 2'h0;
         sseg_r     <= 3'h0;
      end else if (ce) begin
         span_r     <= span_nxt;
         zero_r     <= zero_nxt;
         cspan_r    <= nv_r[`SCE_B_COARSE][`SCE_F_CSPAN];
         czero_r    <= nv_r[`SCE_B_COARSE][`SCE_F_CZERO];
         out_r      <= out_nxt;
         alarm_r    <= alarm_nxt;
         steer_r    <= steer_nxt;
         steer_oe_r <= ctrl_r[`SCE_CTRL_STEER];
         tseg_r     <= tseg_nxt;
         sseg_r     <= sseg_nxt;
      end
   end

   assign prdata             = prdata_r;
   assign pready             = pready_r;
   assign pslverr            = pslverr_r;
   assign span_dac           = span_r;
   assign zero_dac           = zero_r;
   assign coarse_span_select = cspan_r;
   assign coarse_zero_select = czero_r;
   assign corrected_out      = out_r;
   assign alarm_active       = alarm_r;
   assign first_aux_pin_out  = steer_r[0];
   assign second_aux_pin_out = steer_r[1];
   assign first_aux_pin_oe   = steer_oe_r;
   assign second_aux_pin_oe  = steer_oe_r;

   // -------------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      psel && penable && pready;
   endsequence

   property p_apb_answer;
      s_setup ##1 (psel && penable && ce) |-> ##[1:2] pready;
   endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("apb answer late");

   // a completed transfer must not be answered twice
   property p_pready_pulse;
      s_answer ##0 ce |=> !pready;
   endproperty
   a_pready_pulse: assert property (p_pready_pulse) else $error("ready held too long");

   property p_fixed_span;
      ce && tcode == `SCE_TCNT_FIXED |=> span_dac == $past(fixed_span);
   endproperty
   a_fixed_span: assert property (p_fixed_span) else $error("fixed span wrong");

   property p_fixed_zero;
      ce && tcode == `SCE_TCNT_FIXED |=> zero_dac == $past(fixed_zero);
   endproperty
   a_fixed_zero: assert property (p_fixed_zero) else $error("fixed zero wrong");

   property p_coarse;
      ce |=> coarse_span_select == $past(nv_r[`SCE_B_COARSE][`SCE_F_CSPAN])
             && coarse_zero_select == $past(nv_r[`SCE_B_COARSE][`SCE_F_CZERO]);
   endproperty
   a_coarse: assert property (p_coarse) else $error("coarse selection wrong");

   property p_steer_no_alarm;
      ce && ctrl_r[`SCE_CTRL_STEER] |=> !alarm_active ##1 1'b1;
   endproperty
   a_steer_no_alarm: assert property (p_steer_no_alarm) else $error("alarm under steering");

   property p_exclusive;
      !(alarm_active && first_aux_pin_oe);
   endproperty
   a_exclusive: assert property (p_exclusive) else $error("alarm and steering together");

   property p_alarm_low;
      ce && alarm_on && src_lvl < nv_r[`SCE_B_ALM_LT]
      |=> alarm_active && corrected_out == {$past(nv_r[`SCE_B_ALM_LO]), 2'b00};
   endproperty
   a_alarm_low: assert property (p_alarm_low) else $error("low alarm level wrong");

   property p_two_seg;
      ce && tcode == `SCE_TCNT_TWO && temp_f >= tbp[0] |=> tseg_r == 2'h1;
   endproperty
   a_two_seg: assert property (p_two_seg) else $error("two segment decode wrong");

   property p_steer_pins;
      ce && ctrl_r[`SCE_CTRL_STEER] |=> first_aux_pin_oe && second_aux_pin_oe;
   endproperty
   a_steer_pins: assert property (p_steer_pins) else $error("aux pins not driven");

endmodule

// ==== test/sensor_front_end.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// converter model feeding the engine
// ----------------------------------------
module sensor_front_end (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // levels set by the bench
   input  wire logic [9:0]  temp_level,
   input  wire logic [9:0]  sig_level,
   // digitised samples
   output logic      [15:0] temp_filt,
   output logic      [9:0]  temp_sig,
   output logic      [9:0]  sens_sig
);
   // one conversion a clock; adds a cycle like a real converter
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         temp_filt <= 16'h0000;
         temp_sig  <= 10'h000;
         sens_sig  <= 10'h000;
      end else begin
         temp_filt <= {temp_level, 6'h00};
         temp_sig  <= temp_level;
         sens_sig  <= sig_level;
      end
   end
endmodule

// ==== test/sensor_compensation_engine_bench.sv ====
`timescale 1ns/1ps
module sensor_compensation_engine_bench;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic        clk = 0, rst_n = 0, ce = 1, psel = 0, penable = 0, pwrite = 0, e;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd, prdata;
   logic [9:0]  tl = 10'h000, sl = 10'h000, ts, ss, sd, zd, co;
   logic [15:0] tf;
   logic [2:0]  cs;
   logic [3:0]  cz;
   logic        pready, pslverr, al, p1, o1, p2, o2;
   int          err_total = 0, n_compared = 0;
   always #20 clk = ~clk;
   sensor_front_end sensor_front_end_inst (.clk(clk), .rst_n(rst_n), .temp_level(tl),
      .sig_level(sl), .temp_filt(tf), .temp_sig(ts), .sens_sig(ss));
   sensor_compensation_engine sensor_compensation_engine_inst (.clk(clk), .rst_n(rst_n),
      .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .temperature_filtered(tf), .temperature_signal(ts), .amplifier_signal(ss),
      .sensor_signal(ss), .voltage_output(ss), .first_aux_level(ss), .second_aux_level(ss),
      .span_dac(sd), .zero_dac(zd), .coarse_span_select(cs), .coarse_zero_select(cz),
      .corrected_out(co), .alarm_active(al), .first_aux_pin_out(p1),
      .first_aux_pin_oe(o1), .second_aux_pin_out(p2), .second_aux_pin_oe(o2));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task summarize;
      if (err_total == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
      n_compared++;
      if (g !== x) begin
         err_total++;
         $display("[ERR] %0t got %h expected %h", $time, g, x);
      end
   endtask
   // one apb transfer; request held until pready is seen high
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin
         err_total++;
         summarize();
      end
      rd = prdata;
      e  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
   task wb(input logic [5:0] i, input logic [7:0] v);
      bus(1'b1, 12'h100 + {4'h0, i, 2'h0}, {24'h0, v});
   endtask
   // converter plus compute latency; read at the edge, before that edge's updates land
   task settle;
      repeat (3) @(posedge clk);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_fixed;
      chk(sd, 10'h000);
      wb(6'h02, 8'hA5);
      wb(6'h03, 8'h34);
      wb(6'h04, 8'h56);
      wb(6'h11, 8'h21);
      settle();
      chk(cs, 3'h5);
      chk(cz, 4'hA);
      chk(sd, 10'h134);
      chk(zd, 10'h256);
      bus(1'b0, 12'h004, 32'h0);
      chk(rd, {6'h0, 10'h256, 6'h0, 10'h134});
      bus(1'b0, 12'h00C, 32'h0);
      chk({31'h0, e}, 32'h1);
      chk(rd, 32'h0);
   endtask
   // first breakpoint at 200h, two temperature segments
   task t_segments;
      wb(6'h18, 8'h05);
      wb(6'h12, 8'h02);
      wb(6'h13, 8'h00);
      wb(6'h0D, 8'h01);
      tl <= 10'h100;
      settle();
      chk(sd, 10'h034);
      wb(6'h0D, 8'h09);
      settle();
      chk(sd, 10'h234);
      wb(6'h0E, 8'h81);
      wb(6'h08, 8'h80);
      tl <= 10'h240;
      settle();
      chk(sd, 10'h174);
      chk(zd, 10'h236);
      wb(6'h0E, 8'h89);
      settle();
      chk(sd, 10'h0F4);
      wb(6'h07, 8'hFF);
      wb(6'h0E, 8'h8F);
      settle();
      chk(sd, 10'h000);
   endtask
   task t_alarm;
      bus(1'b1, 12'h000, 32'h2);
      wb(6'h1B, 8'h10);
      wb(6'h1C, 8'h20);
      wb(6'h1D, 8'hF0);
      wb(6'h1E, 8'hE0);
      sl <= 10'h020;
      settle();
      chk({al, co}, 11'h480);
      sl <= 10'h3FC;
      settle();
      chk({al, co}, 11'h780);
      sl <= 10'h100;
      settle();
      chk({al, co}, 11'h100);
      wb(6'h1F, 8'h20);
      tl <= 10'h020;
      settle();
      chk({al, co}, 11'h480);
      bus(1'b1, 12'h000, 32'h6);
      wb(6'h1F, 8'h00);
      sl <= 10'h060;
      settle();
      chk({al, o2, o1, p2, p1}, 5'h0D);
      sl <= 10'h3FC;
      settle();
      chk({o2, o1, p2, p1}, 4'hF);
      // both functions off again, so the shared bytes go back to zero
      bus(1'b1, 12'h000, 32'h0);
      for (int k = 27; k < 32; k++) begin
         wb(6'(k), 8'h00);
      end
      settle();
      chk({al, o2, o1, p2, p1}, 5'h00);
   endtask
   // fixed temperature, two signal ranges: unity slope from 0, minus unity from 100h
   task t_digital;
      wb(6'h10, 8'hC4);
      wb(6'h20, 8'h01);
      wb(6'h28, 8'h10);
      wb(6'h29, 8'h80);
      wb(6'h18, 8'h20);
      bus(1'b1, 12'h000, 32'h1);
      sl <= 10'h080;
      settle();
      chk(co, 10'h0C0);
      sl <= 10'h180;
      settle();
      chk(co, 10'h180);
      bus(1'b0, 12'h008, 32'h0);
      chk(rd, 32'h0000_0580);
      // clock enable low must freeze the output register
      ce <= 1'b0;
      sl <= 10'h080;
      settle();
      chk(co, 10'h180);
      ce <= 1'b1;
      settle();
      chk(co, 10'h0C0);
   endtask
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_fixed();
      t_segments();
      t_alarm();
      t_digital();
      summarize();
   end
endmodule
